/* core/bsr_ctrl.sv */
`timescale 1ns/1ns
`include "bsr_defs.svh"

// memory controller end: makes the clock phase, issues bursts, gathers reads
module bsr_ctrl #(
   parameter int ADDR_W = 20,
   parameter int WORD_W = 18
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // mode
   input wire logic legacy_mode,
   // read request
   input wire logic rd_req,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic rd_ready,
   // write request
   input wire logic wr_req,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [4*WORD_W-1:0] wr_data,
   input wire logic [7:0] wr_be_n,
   output logic wr_ready,
   // read return
   output logic [4*WORD_W-1:0] rd_data,
   output logic rd_data_valid,
   // memory pins
   bsr_if.ctrl link
);
   import bsr_pkg::*;

   if (WORD_W != 2 * `BSR_LANE_W) begin : g_bad_width
      $error("bsr_ctrl: WORD_W must be two byte lanes");
   end

   logic k_reg;
   bsr_arb_type prev_reg;
   logic rd_acc, wr_acc;
   logic rps_n_reg, wps_n_reg, lde_n_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [4*WORD_W-1:0] pend_data_reg, send_data_reg;
   logic [7:0] pend_be_reg, send_be_reg;
   logic [`BSR_WR_DLY-1:0] wq_v_reg;
   logic send_act_reg;
   logic [1:0] send_idx_reg;
   logic [WORD_W-1:0] d_reg;
   logic [1:0] be_n_reg;
   logic cap_v_reg;
   logic [1:0] rc_idx_reg;
   logic [WORD_W-1:0] rbuf_reg [0:2];
   logic [4*WORD_W-1:0] rd_data_reg;
   logic rd_data_valid_reg;

   // requests are taken in the half before a positive rise; one op per rise
   always_comb begin
      rd_ready = !k_reg && (prev_reg != BSR_ARB_RD);
      wr_ready = !k_reg && (prev_reg != BSR_ARB_WR) && !(rd_req && rd_ready);
      rd_acc = rd_req && rd_ready;
      wr_acc = wr_req && wr_ready;
   end

   // clock divider: k_reg high marks the positive half
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         k_reg <= 1'b0;
         prev_reg <= BSR_ARB_IDLE;
      end else begin
         k_reg <= !k_reg;
         if (!k_reg) begin
            prev_reg <= rd_acc ? BSR_ARB_RD : (wr_acc ? BSR_ARB_WR : BSR_ARB_IDLE);
         end
      end
   end

   // selects and address registered so they stand in the positive half
   // select with address
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rps_n_reg <= 1'b1;
         wps_n_reg <= 1'b1;
         addr_reg <= '0;
         lde_n_reg <= 1'b1;
      end else begin
         rps_n_reg <= !rd_acc;
         wps_n_reg <= !wr_acc;
         lde_n_reg <= !legacy_mode;
         if (rd_acc) begin
            addr_reg <= rd_addr;
         end else if (wr_acc) begin
            addr_reg <= wr_addr;
         end
      end
   end

   // pending write data; copied out before the next write can land
   always_ff @(posedge clk_sys) begin
      if (wr_acc) begin
         pend_data_reg <= wr_data;
         pend_be_reg <= wr_be_n;
      end
      if (wq_v_reg[`BSR_WR_DLY-1]) begin
         send_data_reg <= pend_data_reg;
         send_be_reg <= pend_be_reg;
      end
   end

   // word sender: lowest word first, one per half cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wq_v_reg <= '0;
         send_act_reg <= 1'b0;
         send_idx_reg <= 2'h0;
         d_reg <= '0;
         be_n_reg <= 2'h3;
      end else begin
         wq_v_reg <= {wq_v_reg[`BSR_WR_DLY-2:0], wr_acc};
         if (wq_v_reg[`BSR_WR_DLY-1]) begin
            send_act_reg <= 1'b1;
            send_idx_reg <= 2'h1;
            d_reg <= pend_data_reg[WORD_W-1:0];
            be_n_reg <= pend_be_reg[1:0];
         end else if (send_act_reg) begin
            send_idx_reg <= send_idx_reg + 2'h1;
            send_act_reg <= (send_idx_reg != 2'h3);
            d_reg <= send_data_reg[send_idx_reg*WORD_W +: WORD_W];
            be_n_reg <= send_be_reg[send_idx_reg*2 +: 2];
         end else begin
            be_n_reg <= 2'h3;
         end
      end
   end

   assign link.k_phase = k_reg;
   assign link.loop_disable_n = lde_n_reg;
   assign link.read_port_select_n = rps_n_reg;
   assign link.write_port_select_n = wps_n_reg;
   assign link.addr = addr_reg;
   assign link.d = d_reg;
   assign link.byte_write_select_n = be_n_reg;

   // the flag leads data by one half, so data is taken one cycle later
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cap_v_reg <= 1'b0;
         rc_idx_reg <= 2'h0;
         rd_data_valid_reg <= 1'b0;
         rd_data_reg <= '0;
      end else begin
         cap_v_reg <= link.read_valid_flag;
         rd_data_valid_reg <= 1'b0;
         if (cap_v_reg) begin
            rc_idx_reg <= rc_idx_reg + 2'h1;
            if (rc_idx_reg == 2'h3) begin
               rd_data_reg <= {link.q, rbuf_reg[2], rbuf_reg[1], rbuf_reg[0]};
               rd_data_valid_reg <= 1'b1;
            end else begin
               rbuf_reg[rc_idx_reg] <= link.q;
            end
         end
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_data_valid = rd_data_valid_reg;

endmodule // bsr_ctrl

/* core/bsr_defs.svh */
`ifndef BSR_DEFS_SVH
`define BSR_DEFS_SVH

// words in one burst
`define BSR_BURST 4
// read latency in half cycles of the positive clock, loop enabled
`define BSR_LAT_LOOP 5
// read latency in half cycles, legacy mode
`define BSR_LAT_LEGACY 2
// half cycles from write address to first data word
`define BSR_WR_DLY 2
// bits in one byte lane
`define BSR_LANE_W 9

`endif

/* core/bsr_device.sv */
`timescale 1ns/1ns
`include "bsr_defs.svh"

module bsr_device #(
   parameter int ADDR_W = 20,
   parameter int WORD_W = 18
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // memory pins
   bsr_if.dev link
);
   import bsr_pkg::*;

   localparam int DEPTH = 1 << ADDR_W;
   localparam int LANE_W = `BSR_LANE_W;
   localparam int RDLY = `BSR_LAT_LOOP - 1;

   // two byte lanes per word is all the select logic serves
   if (WORD_W != 2 * LANE_W) begin : g_bad_width
      $error("bsr_device: WORD_W must be two byte lanes");
   end

   logic [WORD_W-1:0] mem_arr [0:`BSR_BURST-1][0:DEPTH-1];

   logic lde_meta_reg;
   logic lde_reg;
   bsr_arb_type prev_reg;
   logic rd_req, wr_req, rd_go, wr_go;
   logic [RDLY-1:0] rp_v_reg;
   logic [ADDR_W-1:0] rp_a_reg [0:RDLY-1];
   logic ld_go, pre_go, ld_load;
   logic [ADDR_W-1:0] tap_addr, cur_addr;
   logic ld_act_reg;
   logic [1:0] ld_idx_reg, cur_idx;
   logic [ADDR_W-1:0] ld_addr_reg;
   logic [`BSR_WR_DLY-1:0] wq_v_reg;
   logic [ADDR_W-1:0] wq_a_reg [0:`BSR_WR_DLY-1];
   logic wd_act_reg;
   logic [1:0] wd_idx_reg, cap_idx;
   logic [ADDR_W-1:0] wd_addr_reg;
   logic [WORD_W-1:0] wd_data_reg [0:`BSR_BURST-1];
   logic [1:0] wd_be_reg [0:`BSR_BURST-1];
   logic cap, commit, fwd;
   logic [WORD_W-1:0] q_next, arr_word;
   logic [WORD_W-1:0] q_reg;
   logic q_oe_n_reg, valid_reg;

   // the mode strap comes from a pin; two flops before use
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         lde_meta_reg <= 1'b0;
         lde_reg <= 1'b0;
      end else begin
         lde_meta_reg <= link.loop_disable_n;
         lde_reg <= lde_meta_reg;
      end
   end

   // request decode; a cycle without k_phase is a negative half
   always_comb begin
      rd_req = link.k_phase && !link.read_port_select_n;
      wr_req = link.k_phase && !link.write_port_select_n;
      // idle or write before: read first
      rd_go = rd_req && (prev_reg != BSR_ARB_RD);
      wr_go = wr_req && (prev_reg != BSR_ARB_WR) && !rd_go;
   end

   // previous-state tracking, updated on positive rises only
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         prev_reg <= BSR_ARB_IDLE;
      end else if (link.k_phase) begin
         if (rd_go) begin
            prev_reg <= BSR_ARB_RD;
         end else if (wr_go) begin
            prev_reg <= BSR_ARB_WR;
         end else begin
            prev_reg <= BSR_ARB_IDLE;
         end
      end
   end

   // read address line: one stage per half cycle of loop latency, less one for the output register
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rp_v_reg <= '0;
      end else begin
         rp_v_reg <= {rp_v_reg[RDLY-2:0], rd_go};
      end
   end

   always_ff @(posedge clk_sys) begin
      rp_a_reg[0] <= link.addr;
      for (int i = 1; i < RDLY; i++) begin
         rp_a_reg[i] <= rp_a_reg[i-1];
      end
   end

   // tap the line at the depth the mode asks for
   always_comb begin
      if (lde_reg) begin
         ld_go = rp_v_reg[`BSR_LAT_LOOP-2];
         tap_addr = rp_a_reg[`BSR_LAT_LOOP-2];
         pre_go = rp_v_reg[`BSR_LAT_LOOP-3];
      end else begin
         ld_go = rp_v_reg[`BSR_LAT_LEGACY-2];
         tap_addr = rp_a_reg[`BSR_LAT_LEGACY-2];
         pre_go = rd_go;
      end
   end

   // word sequencer of the burst being loaded into the output register
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ld_act_reg <= 1'b0;
         ld_idx_reg <= 2'h0;
      end else if (ld_go) begin
         ld_act_reg <= 1'b1;
         ld_idx_reg <= 2'h1;
      end else if (ld_act_reg) begin
         ld_idx_reg <= ld_idx_reg + 2'h1;
         if (ld_idx_reg == 2'h3) begin
            ld_act_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (ld_go) begin
         ld_addr_reg <= tap_addr;
      end
   end

   always_comb begin
      ld_load = ld_go || ld_act_reg;
      cur_idx = ld_go ? 2'h0 : ld_idx_reg;
      cur_addr = ld_go ? tap_addr : ld_addr_reg;
      arr_word = mem_arr[cur_idx][cur_addr];
      fwd = wd_act_reg && (wd_addr_reg == cur_addr) && (cur_idx < wd_idx_reg);
      q_next = arr_word;
      for (int b = 0; b < 2; b++) begin
         if (fwd && wd_be_reg[cur_idx][b]) begin
            q_next[b*LANE_W +: LANE_W] = wd_data_reg[cur_idx][b*LANE_W +: LANE_W];
         end
      end
   end

   // bursts meet edge to edge, so no gap
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         q_reg <= '0;
         q_oe_n_reg <= 1'b1;
         valid_reg <= 1'b0;
      end else begin
         if (ld_load) begin
            q_reg <= q_next;
         end
         // float once the last burst is out
         q_oe_n_reg <= !ld_load;
         valid_reg <= pre_go || ld_go || (ld_act_reg && ld_idx_reg != 2'h3);
      end
   end

   assign link.q = q_reg;
   assign link.q_oe_n = q_oe_n_reg;
   assign link.read_valid_flag = valid_reg;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wq_v_reg <= '0;
      end else begin
         wq_v_reg <= {wq_v_reg[`BSR_WR_DLY-2:0], wr_go};
      end
   end

   always_ff @(posedge clk_sys) begin
      wq_a_reg[0] <= link.addr;
      for (int i = 1; i < `BSR_WR_DLY; i++) begin
         wq_a_reg[i] <= wq_a_reg[i-1];
      end
   end

   // data is taken only inside an accepted burst
   always_comb begin
      cap = wq_v_reg[`BSR_WR_DLY-1] || wd_act_reg;
      cap_idx = wq_v_reg[`BSR_WR_DLY-1] ? 2'h0 : wd_idx_reg;
      commit = wd_act_reg && (wd_idx_reg == 2'h3);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wd_act_reg <= 1'b0;
         wd_idx_reg <= 2'h0;
      end else if (wq_v_reg[`BSR_WR_DLY-1]) begin
         wd_act_reg <= 1'b1;
         wd_idx_reg <= 2'h1;
      end else if (wd_act_reg) begin
         wd_idx_reg <= wd_idx_reg + 2'h1;
         if (wd_idx_reg == 2'h3) begin
            wd_act_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (wq_v_reg[`BSR_WR_DLY-1]) begin
         wd_addr_reg <= wq_a_reg[`BSR_WR_DLY-1];
      end
      if (cap) begin
         wd_data_reg[cap_idx] <= link.d;
         wd_be_reg[cap_idx] <= ~link.byte_write_select_n;
      end
   end

   // commit all four words at once, the last straight from the pins
   always_ff @(posedge clk_sys) begin
      if (commit) begin
         for (int w = 0; w < `BSR_BURST; w++) begin
            for (int b = 0; b < 2; b++) begin
               if (w == `BSR_BURST - 1) begin
                  if (!link.byte_write_select_n[b]) begin
                     mem_arr[w][wd_addr_reg][b*LANE_W +: LANE_W] <= link.d[b*LANE_W +: LANE_W];
                  end
               end else if (wd_be_reg[w][b]) begin
                  mem_arr[w][wd_addr_reg][b*LANE_W +: LANE_W] <=
                     wd_data_reg[w][b*LANE_W +: LANE_W];
               end
            end
         end
      end
   end
endmodule // bsr_device

/* core/bsr_if.sv */
`timescale 1ns/1ns

// pins between the memory controller and the burst memory
interface bsr_if #(
   parameter int ADDR_W = 20,
   parameter int WORD_W = 18
);
   logic k_phase;
   logic loop_disable_n;
   logic read_port_select_n;
   logic write_port_select_n;
   logic [ADDR_W-1:0] addr;
   logic [WORD_W-1:0] d;
   logic [1:0] byte_write_select_n;
   logic [WORD_W-1:0] q;
   logic q_oe_n;
   logic read_valid_flag;

   modport dev (
      input k_phase, loop_disable_n, read_port_select_n, write_port_select_n,
      input addr, d, byte_write_select_n,
      output q, q_oe_n, read_valid_flag
   );

   modport ctrl (
      output k_phase, loop_disable_n, read_port_select_n, write_port_select_n,
      output addr, d, byte_write_select_n,
      input q, q_oe_n, read_valid_flag
   );
endinterface // bsr_if

/* core/bsr_pkg.sv */
package bsr_pkg;

   // what the port logic initiated at the previous positive rise
   typedef enum logic [2:0] {
      BSR_ARB_IDLE = 3'h1,
      BSR_ARB_RD = 3'h2,
      BSR_ARB_WR = 3'h4
   } bsr_arb_type;

endpackage

/* dv/bsr_link_asserts.sv */
`timescale 1ns/1ns

// watches the pins between the two ends
module bsr_link_asserts (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // memory pins
   input wire logic k_phase,
   input wire logic loop_disable_n,
   input wire logic read_port_select_n,
   input wire logic write_port_select_n,
   input wire logic q_oe_n,
   input wire logic read_valid_flag
);
   logic [3:0] age_reg;
   logic mode_reg;
   logic rd_take;
   logic wr_take;
   logic lp;
   logic lg;

   // a request only counts on a positive half
   assign rd_take = k_phase & ~read_port_select_n;
   assign wr_take = k_phase & ~write_port_select_n;
   // the strap passes two flops, so trust the mode only once it has settled
   always_ff @(posedge clk_sys) begin
      mode_reg <= loop_disable_n;
      if (!rst_b || (loop_disable_n != mode_reg)) begin
         age_reg <= 4'h0;
      end else if (age_reg != 4'hf) begin
         age_reg <= age_reg + 4'h1;
      end
   end
   assign lp = (age_reg > 4'h5) & loop_disable_n;
   assign lg = (age_reg > 4'h5) & ~loop_disable_n;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   property p_rd_loop_q;
      rd_take && lp |-> ##5 !q_oe_n [*4];
   endproperty
   a_rd_loop_q: assert property (p_rd_loop_q)
      else $error("loop mode read burst not driven on time");
   property p_rd_legacy_q;
      rd_take && lg |-> ##2 !q_oe_n [*4];
   endproperty
   a_rd_legacy_q: assert property (p_rd_legacy_q)
      else $error("legacy mode read burst not driven on time");
   property p_flag_legacy;
      rd_take && lg |-> ##1 read_valid_flag [*4];
   endproperty
   a_flag_legacy: assert property (p_flag_legacy)
      else $error("legacy valid flag missing ahead of read data");
   property p_float_legacy;
      (rd_take && lg) ##4 !rd_take |-> ##2 q_oe_n;
   endproperty
   a_float_legacy: assert property (p_float_legacy)
      else $error("legacy read outputs still driven after last burst");
   property p_stream;
      (rd_take && lp) ##4 rd_take |-> ##1 !q_oe_n [*8];
   endproperty
   a_stream: assert property (p_stream)
      else $error("gap between pipelined read bursts");
   property p_float;
      (rd_take && lp) ##4 !rd_take |-> ##5 q_oe_n;
   endproperty
   a_float: assert property (p_float)
      else $error("read outputs still driven after last burst");
   property p_rd_gap;
      rd_take |-> ##2 !rd_take;
   endproperty
   a_rd_gap: assert property (p_rd_gap)
      else $error("reads requested on consecutive rises");
   property p_wr_gap;
      wr_take |-> ##2 !wr_take;
   endproperty
   a_wr_gap: assert property (p_wr_gap)
      else $error("writes requested on consecutive rises");
   property p_k_toggle;
      $past(rst_b) |-> k_phase != $past(k_phase);
   endproperty
   a_k_toggle: assert property (p_k_toggle)
      else $error("clock phase did not alternate");
   property p_flag;
      rd_take && lp |-> ##4 read_valid_flag [*3];
   endproperty
   a_flag: assert property (p_flag)
      else $error("valid flag missing ahead of read data");
   property p_flag_lead;
      $rose(read_valid_flag) && (lp || lg) |=> $fell(q_oe_n);
   endproperty
   a_flag_lead: assert property (p_flag_lead)
      else $error("valid flag does not lead data by one step");
endmodule // bsr_link_asserts

/* dv/separate_port_burst_sram_core_tb.sv */
`timescale 1ns/1ns

// drives the controller end, checks what returns through the memory end
module separate_port_burst_sram_core_tb;
   import bsr_pkg::*;
   localparam int AW = 6;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic legacy_mode = 1'b0;
   logic rd_req = 1'b0;
   logic [AW-1:0] rd_addr = 6'h00;
   logic wr_req = 1'b0;
   logic [AW-1:0] wr_addr = 6'h00;
   logic [71:0] wr_data = 72'h0;
   logic [7:0] wr_be_n = 8'hff;
   logic rd_ready;
   logic wr_ready;
   logic rd_data_valid;
   logic [71:0] rd_data;
   logic [71:0] mem [64];
   logic [71:0] exp_q [$];
   logic rd_took = 1'b0;
   logic wr_took = 1'b0;
   int err_total = 0;
   int check_count = 0;
   int seed = 32'h2939d062;
   int fill = 0;

   bsr_if #(.ADDR_W(AW), .WORD_W(18)) link ();
   bsr_device #(.ADDR_W(AW), .WORD_W(18)) bsr_device_inst (.clk_sys(clk_sys), .rst_b(rst_b),
      .link(link.dev));
   bsr_ctrl #(.ADDR_W(AW), .WORD_W(18)) bsr_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b),
      .legacy_mode(legacy_mode), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready),
      .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_be_n(wr_be_n),
      .wr_ready(wr_ready), .rd_data(rd_data), .rd_data_valid(rd_data_valid), .link(link.ctrl));
   bsr_link_asserts bsr_link_asserts_inst (.clk_sys(clk_sys), .rst_b(rst_b),
      .k_phase(link.k_phase), .loop_disable_n(link.loop_disable_n),
      .read_port_select_n(link.read_port_select_n),
      .write_port_select_n(link.write_port_select_n), .q_oe_n(link.q_oe_n),
      .read_valid_flag(link.read_valid_flag));

   // free-running system clock
   always #5 clk_sys = ~clk_sys;

   task automatic chk72(input logic [71:0] exp, input logic [71:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   task automatic summarize;
      if (err_total == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // note what each taken request means; a write lands at once so reads see it
   always @(posedge clk_sys) begin
      rd_took <= 1'b0;
      wr_took <= 1'b0;
      if (rst_b && rd_req && rd_ready) begin
         exp_q.push_back(mem[rd_addr]);
         rd_took <= 1'b1;
      end else if (rst_b && wr_req && wr_ready) begin
         for (int b = 0; b < 8; b++) begin
            if (!wr_be_n[b]) mem[wr_addr][9*b +: 9] = wr_data[9*b +: 9];
         end
         fill++;
         wr_took <= 1'b1;
      end
   end

   // results return in request order, so the oldest note is the match
   always @(posedge clk_sys) begin
      if (rst_b && rd_data_valid === 1'b1) begin
         // a result with no read outstanding is always a mismatch, unknown data or not
         chk72(72'h1, 72'(exp_q.size() != 0));
         if (exp_q.size() != 0) chk72(exp_q.pop_front(), rd_data);
      end
   end

   // hold each request until taken; rnd low fills every address in turn
   task automatic run(input int n, input logic rnd);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         #1;
         if (rd_took || !rd_req) begin
            rd_req = rnd && ($random(seed) % 4 != 0);
            rd_addr = AW'($random(seed));
         end
         if (wr_took || !wr_req) begin
            wr_req = rnd ? ($random(seed) % 3 != 0) : (fill < 64);
            wr_addr = rnd ? AW'($random(seed)) : AW'(fill);
            wr_data = 72'({$random(seed), $random(seed), $random(seed)});
            wr_be_n = rnd ? 8'($random(seed)) : 8'h00;
         end
      end
   endtask

   // write then read one address at the closest legal spacing; ports must be idle on entry
   task automatic raw(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         #1;
         wr_req = 1'b1;
         wr_addr = AW'($random(seed));
         wr_data = 72'({$random(seed), $random(seed), $random(seed)});
         wr_be_n = 8'($random(seed));
         for (int t = 0; t < 8 && !wr_took; t++) begin
            @(posedge clk_sys);
            #1;
         end
         // a request never taken within its bound counts as a mismatch
         if (!wr_took) err_total++;
         wr_req = 1'b0;
         rd_req = 1'b1;
         rd_addr = wr_addr;
         for (int t = 0; t < 8 && !rd_took; t++) begin
            @(posedge clk_sys);
            #1;
         end
         if (!rd_took) err_total++;
         rd_req = 1'b0;
      end
   endtask

   // deselect both ports and let pending bursts finish
   task automatic quiet(input int n);
      @(posedge clk_sys);
      #1;
      rd_req = 1'b0;
      wr_req = 1'b0;
      repeat (n) @(posedge clk_sys);
   endtask

   initial begin
      repeat (3) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      run(400, 1'b0);
      // a fill that did not finish in time counts against the run
      if (fill != 64) begin
         err_total++;
      end else begin
         run(600, 1'b1);
         quiet(30);
         raw(16);
         quiet(30);
         #1;
         legacy_mode = 1'b1;
         repeat (10) @(posedge clk_sys);
         run(600, 1'b1);
         quiet(30);
         raw(16);
         quiet(30);
      end
      chk72(72'h0, 72'(exp_q.size()));
      summarize();
   end
endmodule // separate_port_burst_sram_core_tb
